// [inc/bst_tap_consts.vh]
`ifndef BST_TAP_CONSTS_VH
`define BST_TAP_CONSTS_VH

// ****************************************************************
// register widths
// ****************************************************************
`define BST_IR_W       8
`define BST_BSR_W      48
`define BST_BCR_W      3
`define BST_ID_W       32

// ****************************************************************
// reset and capture values
// ****************************************************************
`define BST_IR_RESET   8'h81
`define BST_IR_CAPTURE 8'h81
`define BST_BCR_RESET  3'h2
`define BST_BSR_OE_HI  47
`define BST_BSR_OE_LO  46
`define BST_BSR_OE_SET 2'h3
`define BST_BYP_CAPTURE 1'h0
// identification value is arbitrary; bit 0 is one as scan convention wants
`define BST_ID_DEFAULT 32'h00000001

// ****************************************************************
// instruction opcodes
// ****************************************************************
`define BST_OP_IDCODE  8'h81
`define BST_OP_BYPASS  8'hFF
`define BST_OP_EXTEST  8'h00
`define BST_OP_SAMPLE  8'h82
`define BST_OP_RUNT    8'h09
`define BST_OP_BCRSCAN 8'h0E

// ****************************************************************
// data register select codes
// ****************************************************************
`define BST_DR_BYP     2'h0
`define BST_DR_BSR     2'h1
`define BST_DR_BCR     2'h2
`define BST_DR_ID      2'h3

// ****************************************************************
// controller state codes
// ****************************************************************
`define BST_S_TLR      4'h0
`define BST_S_IDLE     4'h1
`define BST_S_SELDR    4'h2
`define BST_S_CAPDR    4'h3
`define BST_S_SHDR     4'h4
`define BST_S_EX1DR    4'h5
`define BST_S_PAUDR    4'h6
`define BST_S_EX2DR    4'h7
`define BST_S_UPDR     4'h8
`define BST_S_SELIR    4'h9
`define BST_S_CAPIR    4'hA
`define BST_S_SHIR     4'hB
`define BST_S_EX1IR    4'hC
`define BST_S_PAUIR    4'hD
`define BST_S_EX2IR    4'hE
`define BST_S_UPIR     4'hF

`endif

// [logic/bst_pin_sync.v]
`timescale 1ns/1ps
`default_nettype none

// two-stage synchroniser per pin with edge pulses taken after stage two
module bst_pin_sync #(
  parameter W = 3
) (
  input  wire         clk,
  input  wire         rst,
  input  wire [W-1:0] pin_in,
  output reg  [W-1:0] sync_out,
  output reg  [W-1:0] rise_out,
  output reg  [W-1:0] fall_out
);

  reg [W-1:0] meta_reg;
  reg [W-1:0] prev_reg;

  // ****************************************************************
  // synchroniser stages and edge detect
  // ****************************************************************
  always @(posedge clk) begin
    if (rst) begin
      meta_reg <= {W{1'b0}};
      sync_out <= {W{1'b0}};
      prev_reg <= {W{1'b0}};
      rise_out <= {W{1'b0}};
      fall_out <= {W{1'b0}};
    end else begin
      meta_reg <= pin_in;
      sync_out <= meta_reg;
      prev_reg <= sync_out;
      rise_out <= sync_out & ~prev_reg;
      fall_out <= ~sync_out & prev_reg;
    end
  end

endmodule

`default_nettype wire

// [logic/bst_tap_ctrl.v]
`timescale 1ns/1ps
`default_nettype none
`include "bst_tap_consts.vh"

// Overview of operation
// R1 - sample on test clock rise, drive on fall
// R2 - instruction, boundary, control, bypass, identification registers
// R3 - sixteen states stepped by mode select
// R4 - one register connected for access at once
// R5 - reset state disables test logic
// R6 - mode select high reaches reset within five
// R7 - reset loads instruction 10000001
// R8 - reset sets boundary cells 47 and 46
// R9 - reset loads boundary control 010
// R10 - operations run only while idle
// R11 - scan select states leave next cycle
// R12 - data capture on edge leaving capture
// R13 - output drives lsb after shift entry
// R14 - shift on each rise, not entry edge
// R15 - output floats after first exit entry
// R16 - exit may return to shift, contents kept
// R17 - pause holds contents indefinitely
// R18 - data update on fall in update
// R19 - instruction capture loads 10000001
// R20 - new instruction current on update fall
// R21 - latches except bypass and identification
// R22 - capture, shift toward output, update latches
// R23 - bypass captures zero
// R24 - unimplemented opcodes act as bypass
// R25 - host changes inputs on fall
// R26 - host forces reset before scanning
module bst_tap_ctrl #(
  parameter [`BST_ID_W-1:0] ID_CODE = `BST_ID_DEFAULT
) (
  input  wire                  clk,
  input  wire                  rst,
  input  wire                  tck_pin,
  input  wire                  tms_pin,
  input  wire                  tdi_pin,
  input  wire [`BST_BSR_W-1:0] bsr_capture_in,
  output reg                   tdo_reg,
  output reg                   tdo_oe_n_reg,
  output reg  [3:0]            tap_state_reg,
  output reg  [`BST_IR_W-1:0]  ir_latch_reg,
  output reg  [`BST_BSR_W-1:0] bsr_latch_reg,
  output reg  [`BST_BCR_W-1:0] boundary_op_select_reg,
  output reg                   test_mode_reg,
  output reg                   run_op_en_reg,
  output reg                   test_logic_reset_reg
);

  // ****************************************************************
  // controller states
  // ****************************************************************
  localparam S_TLR   = `BST_S_TLR;
  localparam S_IDLE  = `BST_S_IDLE;
  localparam S_SELDR = `BST_S_SELDR;
  localparam S_CAPDR = `BST_S_CAPDR;
  localparam S_SHDR  = `BST_S_SHDR;
  localparam S_EX1DR = `BST_S_EX1DR;
  localparam S_PAUDR = `BST_S_PAUDR;
  localparam S_EX2DR = `BST_S_EX2DR;
  localparam S_UPDR  = `BST_S_UPDR;
  localparam S_SELIR = `BST_S_SELIR;
  localparam S_CAPIR = `BST_S_CAPIR;
  localparam S_SHIR  = `BST_S_SHIR;
  localparam S_EX1IR = `BST_S_EX1IR;
  localparam S_PAUIR = `BST_S_PAUIR;
  localparam S_EX2IR = `BST_S_EX2IR;
  localparam S_UPIR  = `BST_S_UPIR;

  // ****************************************************************
  // pin levels, edges and shift stages of the test registers
  // ****************************************************************
  wire [2:0]            pin_sync;
  wire [2:0]            pin_rise;
  wire [2:0]            pin_fall;
  wire                  tck_rise;
  wire                  tck_fall;
  wire                  tms_s;
  wire                  tdi_s;
  wire [1:0]            dr_sel;
  reg  [`BST_IR_W-1:0]  ir_shift_reg;  // [R2]
  reg  [`BST_BSR_W-1:0] bsr_shift_reg; // [R2]
  reg  [`BST_BCR_W-1:0] bcr_shift_reg; // [R2]
  reg                   byp_shift_reg; // [R2]
  reg  [`BST_ID_W-1:0]  id_shift_reg;  // [R2]

  // ****************************************************************
  // functions
  // ****************************************************************

  // next controller state from the mode select level
  function [3:0] next_state;
    input [3:0] s;
    input       tms;
    begin
      case (s)
        S_TLR:   next_state = tms ? S_TLR   : S_IDLE;
        S_IDLE:  next_state = tms ? S_SELDR : S_IDLE;
        S_SELDR: next_state = tms ? S_SELIR : S_CAPDR;
        S_CAPDR: next_state = tms ? S_EX1DR : S_SHDR;
        S_SHDR:  next_state = tms ? S_EX1DR : S_SHDR;
        S_EX1DR: next_state = tms ? S_UPDR  : S_PAUDR;
        S_PAUDR: next_state = tms ? S_EX2DR : S_PAUDR;
        S_EX2DR: next_state = tms ? S_UPDR  : S_SHDR;
        S_UPDR:  next_state = tms ? S_SELDR : S_IDLE;
        S_SELIR: next_state = tms ? S_TLR   : S_CAPIR;
        S_CAPIR: next_state = tms ? S_EX1IR : S_SHIR;
        S_SHIR:  next_state = tms ? S_EX1IR : S_SHIR;
        S_EX1IR: next_state = tms ? S_UPIR  : S_PAUIR;
        S_PAUIR: next_state = tms ? S_EX2IR : S_PAUIR;
        S_EX2IR: next_state = tms ? S_UPIR  : S_SHIR;
        S_UPIR:  next_state = tms ? S_SELDR : S_IDLE;
        default: next_state = S_TLR;
      endcase
    end
  endfunction

  // data register selected by an instruction; unknown codes take bypass
  function [1:0] dr_decode;
    input [`BST_IR_W-1:0] op;
    begin
      case (op)
        `BST_OP_IDCODE:  dr_decode = `BST_DR_ID;
        `BST_OP_EXTEST:  dr_decode = `BST_DR_BSR;
        `BST_OP_SAMPLE:  dr_decode = `BST_DR_BSR;
        `BST_OP_BCRSCAN: dr_decode = `BST_DR_BCR;
        default:         dr_decode = `BST_DR_BYP; // [R24]
      endcase
    end
  endfunction

  // instructions that take the device out of normal mode
  function is_test_op;
    input [`BST_IR_W-1:0] op;
    begin
      is_test_op = (op == `BST_OP_EXTEST) || (op == `BST_OP_RUNT);
    end
  endfunction

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  bst_pin_sync #(
    .W (3)
  ) u_sync (
    .clk      (clk),
    .rst      (rst),
    .pin_in   ({tdi_pin, tms_pin, tck_pin}),
    .sync_out (pin_sync),
    .rise_out (pin_rise),
    .fall_out (pin_fall)
  );

  // ****************************************************************
  // test clock edges and register select
  // ****************************************************************
  // edge pulses of the test clock, levels of the serial inputs
  assign tck_rise = pin_rise[0];
  assign tck_fall = pin_fall[0];
  assign tms_s    = pin_sync[1];
  assign tdi_s    = pin_sync[2];

  // data register placed between serial input and output
  assign dr_sel   = dr_decode(ir_latch_reg); // [R4]

  // ****************************************************************
  // state machine, stepped on the test clock rise
  // ****************************************************************
  always @(posedge clk) begin
    if (rst) begin
      tap_state_reg <= S_TLR; // [R5]
    end else if (tck_rise) begin
      // mode select level at each detected test clock rise picks the next state
      tap_state_reg <= next_state(tap_state_reg, tms_s); // [R1] [R3] [R6] [R11]
    end
  end

  // ****************************************************************
  // shift stages: capture on leaving capture, shift while shifting
  // ****************************************************************
  always @(posedge clk) begin
    if (rst) begin
      ir_shift_reg  <= `BST_IR_RESET;
      bsr_shift_reg <= {`BST_BSR_W{1'b0}};
      bcr_shift_reg <= `BST_BCR_RESET;
      byp_shift_reg <= `BST_BYP_CAPTURE;
      id_shift_reg  <= ID_CODE;
    end else if (tck_rise) begin
      case (tap_state_reg)
        S_CAPIR: begin
          ir_shift_reg <= `BST_IR_CAPTURE; // [R19]
        end
        S_SHIR: begin
          ir_shift_reg <= {tdi_s, ir_shift_reg[`BST_IR_W-1:1]}; // [R14] [R22]
        end
        S_CAPDR: begin
          // control register shift stage keeps its contents on capture
          case (dr_sel)
            `BST_DR_BSR: bsr_shift_reg <= bsr_capture_in; // [R12]
            `BST_DR_ID:  id_shift_reg  <= ID_CODE;        // [R12]
            `BST_DR_BYP: byp_shift_reg <= `BST_BYP_CAPTURE; // [R23]
            default:     bcr_shift_reg <= bcr_shift_reg;
          endcase
        end
        S_SHDR: begin
          // only the selected register moves; pause and exit states hold all
          case (dr_sel)
            `BST_DR_BSR: bsr_shift_reg <= {tdi_s, bsr_shift_reg[`BST_BSR_W-1:1]}; // [R14] [R22]
            `BST_DR_BCR: bcr_shift_reg <= {tdi_s, bcr_shift_reg[`BST_BCR_W-1:1]}; // [R14] [R16]
            `BST_DR_ID:  id_shift_reg  <= {tdi_s, id_shift_reg[`BST_ID_W-1:1]};   // [R14] [R17]
            default:     byp_shift_reg <= tdi_s; // [R14]
          endcase
        end
        default: begin
          ir_shift_reg <= ir_shift_reg;
        end
      endcase
    end
  end

  // ****************************************************************
  // serial output, changed on the test clock fall
  // ****************************************************************
  always @(posedge clk) begin
    if (rst) begin
      tdo_reg      <= 1'b0;
      tdo_oe_n_reg <= 1'b1;
    end else if (tck_fall) begin
      case (tap_state_reg)
        S_SHIR: begin
          tdo_reg      <= ir_shift_reg[0]; // [R1] [R13]
          tdo_oe_n_reg <= 1'b0;
        end
        S_SHDR: begin
          case (dr_sel)
            `BST_DR_BSR: tdo_reg <= bsr_shift_reg[0]; // [R13]
            `BST_DR_BCR: tdo_reg <= bcr_shift_reg[0];
            `BST_DR_ID:  tdo_reg <= id_shift_reg[0];
            default:     tdo_reg <= byp_shift_reg;
          endcase
          tdo_oe_n_reg <= 1'b0; // [R13]
        end
        S_EX1IR, S_EX1DR: begin
          tdo_oe_n_reg <= 1'b1; // [R15]
        end
        default: begin
          tdo_oe_n_reg <= 1'b1;
        end
      endcase
    end
  end

  // ****************************************************************
  // output latches, instruction and mode
  // ****************************************************************
  always @(posedge clk) begin
    if (rst || tap_state_reg == S_TLR) begin
      ir_latch_reg           <= `BST_IR_RESET;  // [R7]
      bsr_latch_reg[`BST_BSR_OE_HI:`BST_BSR_OE_LO] <= `BST_BSR_OE_SET; // [R8]
      boundary_op_select_reg <= `BST_BCR_RESET; // [R9]
      test_mode_reg          <= 1'b0;           // [R5]
      // low cells carry no reset value; cleared on rst only for clean sim
      if (rst) begin
        bsr_latch_reg[`BST_BSR_OE_LO-1:0] <= {`BST_BSR_OE_LO{1'b0}};
      end
    end else if (tck_fall) begin
      case (tap_state_reg)
        S_UPIR: begin
          // mode change takes effect together with the new instruction
          ir_latch_reg  <= ir_shift_reg;             // [R20] [R22]
          test_mode_reg <= is_test_op(ir_shift_reg); // [R20]
        end
        S_UPDR: begin
          // bypass and identification have no latches to update
          case (dr_sel)
            `BST_DR_BSR: bsr_latch_reg <= bsr_shift_reg; // [R18] [R21]
            `BST_DR_BCR: boundary_op_select_reg <= bcr_shift_reg; // [R18] [R21]
            default:     ir_latch_reg <= ir_latch_reg;
          endcase
        end
        default: begin
          ir_latch_reg <= ir_latch_reg;
        end
      endcase
    end
  end

  // ****************************************************************
  // status flags
  // ****************************************************************
  always @(posedge clk) begin
    if (rst) begin
      run_op_en_reg        <= 1'b0;
      test_logic_reset_reg <= 1'b1;
    end else begin
      run_op_en_reg        <= (tap_state_reg == S_IDLE) && (ir_latch_reg == `BST_OP_RUNT); // [R10]
      test_logic_reset_reg <= (tap_state_reg == S_TLR); // [R5]
    end
  end

endmodule

`default_nettype wire

// [sim/bst_tap_chk.sv]
`timescale 1ns/1ps
`default_nettype none
`include "bst_tap_consts.vh"

// ****************************************
// link and state checks at the ports
// ****************************************
module bst_tap_chk (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        tck_pin,
  input wire logic        tdo_reg,
  input wire logic        tdo_oe_n_reg,
  input wire logic [3:0]  tap_state_reg,
  input wire logic [7:0]  ir_latch_reg,
  input wire logic [47:0] bsr_latch_reg,
  input wire logic [2:0]  boundary_op_select_reg,
  input wire logic        run_op_en_reg,
  input wire logic        test_logic_reset_reg
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // reset leaves the controller in its reset state with the id instruction
  chk_release_tlr_ir: assert property ($fell(rst) |-> tap_state_reg == `BST_S_TLR
    && ir_latch_reg == `BST_IR_RESET)
    else $error("state or instruction wrong after reset");
  chk_tlr_reload_vals: assert property (tap_state_reg == `BST_S_TLR |=>
    ir_latch_reg == `BST_IR_RESET && boundary_op_select_reg == `BST_BCR_RESET && bsr_latch_reg[47:46] == 2'h3)
    else $error("reset state latch values wrong");
  chk_reset_flag: assert property (test_logic_reset_reg |-> $past(tap_state_reg) == `BST_S_TLR)
    else $error("reset flag outside reset state");
  chk_run_only_idle: assert property (run_op_en_reg |->
    $past(tap_state_reg) == `BST_S_IDLE && ir_latch_reg == `BST_OP_RUNT)
    else $error("run enable outside idle");
  chk_oe_shift_win: assert property (!tdo_oe_n_reg |->
    tap_state_reg inside {`BST_S_SHDR, `BST_S_EX1DR, `BST_S_SHIR, `BST_S_EX1IR})
    else $error("serial output driven outside shift");
  chk_out_on_fall: assert property ($changed(tdo_reg) || $changed(tdo_oe_n_reg) |->
    !tck_pin && !$past(tck_pin, 3))
    else $error("serial output moved outside clock low");
  chk_state_on_rise: assert property ($changed(tap_state_reg) |-> tck_pin && $past(tck_pin, 3))
    else $error("state moved outside clock high");
  chk_seldr_leaves: assert property (tap_state_reg == `BST_S_SELDR |->
    ##[1:24] tap_state_reg inside {`BST_S_CAPDR, `BST_S_SELIR})
    else $error("data select state held");
  chk_selir_leaves: assert property (tap_state_reg == `BST_S_SELIR |->
    ##[1:24] tap_state_reg inside {`BST_S_CAPIR, `BST_S_TLR})
    else $error("instruction select state held");
  chk_ir_upd_only: assert property ($changed(ir_latch_reg) |->
    tap_state_reg inside {`BST_S_UPIR, `BST_S_TLR})
    else $error("instruction changed outside update");
  chk_dr_upd_only: assert property ($changed(bsr_latch_reg) || $changed(boundary_op_select_reg) |->
    tap_state_reg inside {`BST_S_UPDR, `BST_S_TLR})
    else $error("data latch changed outside update");

  // main scenarios seen
  cov_run: cover property (run_op_en_reg);
  cov_drive: cover property ($fell(tdo_oe_n_reg));
  cov_pause: cover property (tap_state_reg == `BST_S_PAUDR);
endmodule

bind bst_tap_ctrl bst_tap_chk u_chk (.clk, .rst, .tck_pin, .tdo_reg, .tdo_oe_n_reg, .tap_state_reg, .ir_latch_reg,
  .bsr_latch_reg, .boundary_op_select_reg, .run_op_en_reg, .test_logic_reset_reg);

`default_nettype wire

// [sim/bst_host_model.sv]
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// external scan controller model
// ****************************************
module bst_host_model (
  input  wire logic clk,
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  input  wire logic tdo,
  input  wire logic tdo_oe_n
);
  // link clock stands low between frames, inputs idle at pull-up level
  initial begin
    tck = 1'h0;
    tms = 1'h1;
    tdi = 1'h1;
  end

  // one link cycle: inputs move with the fall, output read at the rise
  task automatic tick(input logic m, input logic d, output logic q);
    tms = m;
    tdi = d;
    repeat (10) @(negedge clk);
    tck = 1'h1;
    q = tdo_oe_n ? 1'hZ : tdo;
    repeat (10) @(negedge clk);
    tck = 1'h0;
  endtask

  // five cycles with mode select high, then into idle
  task automatic go_reset();
    logic q;
    repeat (5) tick(1'h1, 1'h1, q);
    tick(1'h0, 1'h1, q);
  endtask

  // scan from idle back to idle, optional pause after bit hold
  task automatic scan(input logic ir, input int n, input logic [47:0] din, input int hold, output logic [47:0] dout);
    logic q;
    dout = 48'h0;
    tick(1'h1, 1'h1, q);
    if (ir) tick(1'h1, 1'h1, q);
    tick(1'h0, 1'h1, q);
    tick(1'h0, 1'h1, q);
    for (int i = 0; i < n; i++) begin
      tick(i == n - 1 || i == hold, din[i], q);
      dout[i] = q;
      if (i == hold && i != n - 1) begin
        tick(1'h0, 1'h1, q);
        tick(1'h0, 1'h1, q);
        tick(1'h1, 1'h1, q);
        tick(1'h0, 1'h1, q);
      end
    end
    tick(1'h1, 1'h1, q);
    tick(1'h0, 1'h1, q);
  endtask
endmodule

`default_nettype wire

// [sim/bst_tap_ctrl_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
`include "bst_tap_consts.vh"

// ****************************************
// testbench top
// ****************************************
module bst_tap_ctrl_tb_top;
  localparam logic [31:0] ID_VAL = 32'hA5C30F01; // arbitrary identification value
  logic        clk, rst, tck, tms, tdi, tdo, oe_n, test_mode, run_en, tlr_flag;
  logic [3:0]  state;
  logic [7:0]  ir_q;
  logic [2:0]  bcr_q;
  logic [47:0] bsr_q, cap_in, got;
  int          num_errors = 0;
  int          samples_checked = 0;
  int          cycles = 0;

  bst_tap_ctrl #(.ID_CODE(ID_VAL)) u_dut (.clk(clk), .rst(rst), .tck_pin(tck), .tms_pin(tms), .tdi_pin(tdi),
    .bsr_capture_in(cap_in), .tdo_reg(tdo), .tdo_oe_n_reg(oe_n), .tap_state_reg(state), .ir_latch_reg(ir_q),
    .bsr_latch_reg(bsr_q), .boundary_op_select_reg(bcr_q), .test_mode_reg(test_mode), .run_op_en_reg(run_en),
    .test_logic_reset_reg(tlr_flag));
  bst_host_model u_host (.clk(clk), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe_n(oe_n));

  // clock and hang guard
  initial begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors++;
      close_out();
    end
  end

  task automatic close_out();
    if (num_errors == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic check(input logic [47:0] seen, input logic [47:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic t_reset_values();
    check(state, `BST_S_TLR);
    check(ir_q, `BST_IR_RESET);
    check(bcr_q, `BST_BCR_RESET);
    check(bsr_q[47:46], `BST_BSR_OE_SET);
    check({tlr_flag, oe_n, test_mode}, 3'h6);
  endtask

  task automatic t_idcode();
    u_host.go_reset();
    check(tlr_flag, 1'h0);
    u_host.scan(1'h0, 32, 48'h123456789ABC, 99, got);
    check(got[31:0], ID_VAL);
    check(oe_n, 1'h1);
  endtask

  // instruction capture value, then bypass path for a known and an unknown code
  task automatic t_bypass();
    u_host.scan(1'h1, 8, 48'hFF, 99, got);
    check(got[7:0], `BST_IR_CAPTURE);
    check(ir_q, `BST_OP_BYPASS);
    u_host.scan(1'h0, 4, 48'hB, 99, got);
    check(got[3:0], 4'h6);
    u_host.scan(1'h1, 8, 48'h33, 99, got);
    u_host.scan(1'h0, 3, 48'h5, 99, got);
    check(got[2:0], 3'h2);
  endtask

  // control register scan with a pause, then the run instruction in idle
  task automatic t_control();
    u_host.scan(1'h1, 8, `BST_OP_BCRSCAN, 99, got);
    u_host.scan(1'h0, 3, 48'h5, 1, got);
    check(got[2:0], `BST_BCR_RESET);
    check(bcr_q, 3'h5);
    u_host.scan(1'h1, 8, `BST_OP_RUNT, 99, got);
    check({run_en, test_mode}, 2'h3);
    u_host.go_reset();
    check({run_en, bcr_q}, 4'h2);
  endtask

  // pin capture and boundary update, then forced reset from idle
  task automatic t_extest();
    logic q;
    @(negedge clk);
    cap_in = 48'h123456789ABC;
    u_host.scan(1'h1, 8, `BST_OP_EXTEST, 99, got);
    check(test_mode, 1'h1);
    u_host.scan(1'h0, 48, 48'h0F0F3C3CA5A5, 20, got);
    check(got, 48'h123456789ABC);
    check(bsr_q, 48'h0F0F3C3CA5A5);
    cap_in = 48'hFEDCBA987654;
    u_host.scan(1'h1, 8, `BST_OP_SAMPLE, 99, got);
    check(test_mode, 1'h0);
    u_host.scan(1'h0, 48, 48'h0, 99, got);
    check(got, 48'hFEDCBA987654);
    repeat (5) u_host.tick(1'h1, 1'h1, q);
    check(state, `BST_S_TLR);
    check({ir_q, bsr_q[47:46]}, {`BST_IR_RESET, 2'h3});
    u_host.tick(1'h0, 1'h1, q);
  endtask

  // reset taken in the middle of a sequence
  task automatic t_mid_reset();
    logic q;
    u_host.tick(1'h1, 1'h1, q);
    @(negedge clk);
    rst = 1'h1;
    repeat (4) @(negedge clk);
    rst = 1'h0;
    repeat (2) @(negedge clk);
    check({state, oe_n}, {`BST_S_TLR, 1'h1});
    u_host.go_reset();
    check(state, `BST_S_IDLE);
  endtask

  initial begin
    rst = 1'h1;
    cap_in = 48'h0;
    repeat (12) @(negedge clk);
    rst = 1'h0;
    repeat (8) @(negedge clk);
    t_reset_values();
    t_idcode();
    t_bypass();
    t_control();
    t_extest();
    t_mid_reset();
    close_out();
  end
endmodule

`default_nettype wire
